// ==== logic/wid_wakeup_input_debouncer.v ====
// wake-up input debouncer: enable/polarity, shared debounce, source capture,
// two tamper debouncers, sensor drive waveform, APB registers and interrupt
// assumes asynchronous pins, a single pclk and an APB master on pclk
//
// Notes on behaviour
// - an input joins shared-debounce wake detection only while its enable bit is one
// - per-input polarity bit picks high or low as the active level
// - qualified active inputs are OR-combined into one shared debounce counter
// - debounce select picks 3, 32, 512, 4096 or 32768 slow clock cycles
// - select zero wakes at once after one slow period of activity
// - activity lasting past the chosen period starts a core supply wake-up
// - at a shared-debounce wake-up start all input states are captured into supply status; tamper wake-ups capture nothing
// - a later wake-up overwrites the earlier captured source
// - inputs zero and one each have their own low-power tamper debouncer
// - tamper wake-up happens only if its tamper debounce enable is set
// - tamper detection also works while the core supply is powered
// - the sensor drive waveform is produced in every power mode
//
// Implementation choices: the address map and the APB interface to the registers.
`include "wid_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module wid_wakeup_input_debouncer
#(
  parameter SLOW_DIV = `WID_SLOW_DIV
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`WID_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [`WID_NUM_INPUTS-1:0] wake_input,
  output reg core_supply_wake,
  output reg [1:0] rtc_waveform_out,
  output reg irq
);

  localparam N = `WID_NUM_INPUTS;
  // last divider count; the slow period is only as exact as SLOW_DIV allows
  localparam [15:0] SLOW_LAST = SLOW_DIV[15:0] - 16'h0001;

  // ==========================================
  // pin synchronisers
  reg [N-1:0] pin_meta;
  reg [N-1:0] pin_sync;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= {N{1'b0}};
      pin_sync <= {N{1'b0}};
    end
    else
    begin
      pin_meta <= wake_input;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================
  // slow clock enable
  reg [15:0] div_cnt;
  reg slow_tick;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 16'h0000;
      slow_tick <= 1'b0;
    end
    else if (div_cnt >= SLOW_LAST)
    begin
      div_cnt <= 16'h0000;
      slow_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      slow_tick <= 1'b0;
    end
  end

  // ==========================================
  // configuration registers
  reg [2:0] wake_debounce_select;
  reg [1:0] tamper_debounce_enable;
  reg [N-1:0] wake_input_enable;
  reg [N-1:0] wake_level_polarity;
  reg [N-1:0] supply_status;
  reg wake_seen;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;

  // ==========================================
  // qualification and shared debounce
  wire [N-1:0] qualified;
  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1)
    begin : g_qual
      // polarity one means high is active
      assign qualified[gi] = wake_input_enable[gi] &
        ~(pin_sync[gi] ^ wake_level_polarity[gi]);
    end
  endgenerate

  wire any_active = |qualified;

  reg [15:0] dbc_limit;
  always @*
  begin
    case (wake_debounce_select)
      3'h0: dbc_limit = `WID_DBC_0;
      3'h1: dbc_limit = `WID_DBC_1;
      3'h2: dbc_limit = `WID_DBC_2;
      3'h3: dbc_limit = `WID_DBC_3;
      3'h4: dbc_limit = `WID_DBC_4;
      default: dbc_limit = `WID_DBC_5;
    endcase
  end

  reg [15:0] dbc_cnt;
  reg dbc_done;
  // fire one tick after the count reaches the limit, so the input has been
  // active for longer than the period, never for a partial first tick only
  wire wake_fire = slow_tick & any_active & ~dbc_done & (dbc_cnt >= dbc_limit);

  // held condition fires once; a fresh wake needs the inputs to go idle first
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dbc_cnt <= 16'h0000;
      dbc_done <= 1'b0;
    end
    else if (!any_active)
    begin
      dbc_cnt <= 16'h0000;
      dbc_done <= 1'b0;
    end
    else if (wake_fire)
    begin
      dbc_done <= 1'b1;
    end
    else if (slow_tick && !dbc_done)
    begin
      dbc_cnt <= dbc_cnt + 16'h0001;
    end
  end

  // ==========================================
  // tamper debouncers on inputs zero and one
  wire [1:0] tamp_fire;

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_tamp
      reg [3:0] tcnt;
      reg tdone;
      // independent of any power state, so it runs with the core up too
      wire tact = ~(pin_sync[gi] ^ wake_level_polarity[gi]);
      assign tamp_fire[gi] = slow_tick & tact & ~tdone & tamper_debounce_enable[gi] &
        (tcnt + 4'h1 >= `WID_TAMP_DBC);
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tcnt <= 4'h0;
          tdone <= 1'b0;
        end
        else if (!tact || !tamper_debounce_enable[gi])
        begin
          tcnt <= 4'h0;
          tdone <= 1'b0;
        end
        else if (tamp_fire[gi])
        begin
          tdone <= 1'b1;
        end
        else if (slow_tick && !tdone)
        begin
          tcnt <= tcnt + 4'h1;
        end
      end
    end
  endgenerate

  // ==========================================
  // sensor drive waveform: one slow period on in every sixteen
  reg [3:0] drive_cnt;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_cnt <= 4'h0;
      rtc_waveform_out <= 2'b00;
    end
    else if (slow_tick)
    begin
      drive_cnt <= (drive_cnt == `WID_DRIVE_PERIOD) ? 4'h0 : drive_cnt + 4'h1;
      rtc_waveform_out <= {2{drive_cnt == 4'h0}};
    end
  end

  // ==========================================
  // wake request and source capture
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_supply_wake <= 1'b0;
      supply_status <= {N{1'b0}};
      wake_seen <= 1'b0;
    end
    else
    begin
      // tamper wakes leave the captured source alone
      core_supply_wake <= wake_fire | (|tamp_fire);
      if (wake_fire)
      begin
        supply_status <= pin_sync;
        wake_seen <= 1'b1;
      end
    end
  end

  // ==========================================
  // APB slave: zero-wait answer, decoded in the setup cycle
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire do_write = access & pwrite & ~pslverr;

  reg [31:0] next_prdata;
  reg next_err;
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `WID_OFF_MODE:
        next_prdata = {26'h0, tamper_debounce_enable, 1'b0, wake_debounce_select};
      `WID_OFF_INPUT:
        next_prdata = {wake_level_polarity, wake_input_enable};
      `WID_OFF_STATUS:
        next_prdata = {15'h0, wake_seen, supply_status};
      `WID_OFF_IRQ_STATUS:
        next_prdata = {29'h0, irq_status};
      `WID_OFF_IRQ_MASK:
        next_prdata = {29'h0, irq_mask};
      // live pin view lets software check idle inputs before backup
      `WID_OFF_PINS:
        next_prdata = {16'h0, pin_sync};
      default:
        next_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_err;
      end
      else if (access)
      begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================
  // register writes and interrupt
  wire [2:0] irq_events = {tamp_fire[1], tamp_fire[0], wake_fire};
  wire status_wr = do_write && paddr == `WID_OFF_IRQ_STATUS;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_debounce_select <= `WID_RST_DBC;
      tamper_debounce_enable <= `WID_RST_TAMP;
      wake_input_enable <= `WID_RST_EN;
      wake_level_polarity <= `WID_RST_POL;
      irq_mask <= `WID_RST_IRQ_MASK;
    end
    else
    begin
      if (do_write && paddr == `WID_OFF_MODE)
      begin
        wake_debounce_select <= pwdata[`WID_MODE_DBC_MSB:`WID_MODE_DBC_LSB];
        tamper_debounce_enable <= {pwdata[`WID_MODE_TAMP1_BIT], pwdata[`WID_MODE_TAMP0_BIT]};
      end
      if (do_write && paddr == `WID_OFF_INPUT)
      begin
        wake_input_enable <= pwdata[`WID_INPUT_EN_LSB+N-1:`WID_INPUT_EN_LSB];
        wake_level_polarity <= pwdata[`WID_INPUT_POL_LSB+N-1:`WID_INPUT_POL_LSB];
      end
      if (do_write && paddr == `WID_OFF_IRQ_MASK)
        irq_mask <= pwdata[2:0];
    end
  end

  // ==========================================
  // interrupt status and line
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= `WID_RST_IRQ_STATUS;
      irq <= 1'b0;
    end
    else
    begin
      // a new event in the clearing cycle survives the clear
      irq_status <= (irq_status & ~(status_wr ? pwdata[2:0] : 3'h0)) | irq_events;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

`default_nettype wire

// ==== logic/wid_defines.vh ====
// constants of the wake-up input debouncer: offsets, fields, resets, timing
// assumes a 100 MHz pclk and a nominal 32.768 kHz slow clock made from it
`ifndef WID_DEFINES_VH
`define WID_DEFINES_VH

// ==========================================
// sizes
`define WID_NUM_INPUTS 16
`define WID_ADDR_W 8

// ==========================================
// register byte offsets
`define WID_OFF_MODE 8'h00
`define WID_OFF_INPUT 8'h04
`define WID_OFF_STATUS 8'h08
`define WID_OFF_IRQ_STATUS 8'h0C
`define WID_OFF_IRQ_MASK 8'h10
`define WID_OFF_PINS 8'h14

// ==========================================
// field positions
`define WID_MODE_DBC_LSB 0
`define WID_MODE_DBC_MSB 2
`define WID_MODE_TAMP0_BIT 4
`define WID_MODE_TAMP1_BIT 5
`define WID_INPUT_EN_LSB 0
`define WID_INPUT_POL_LSB 16
`define WID_STATUS_WAKE_BIT 16
`define WID_IRQ_WAKE_BIT 0
`define WID_IRQ_TAMP0_BIT 1
`define WID_IRQ_TAMP1_BIT 2

// ==========================================
// reset values
`define WID_RST_DBC 3'h0
`define WID_RST_TAMP 2'h0
`define WID_RST_EN 16'h0000
`define WID_RST_POL 16'h0000
`define WID_RST_IRQ_MASK 3'h0
`define WID_RST_IRQ_STATUS 3'h0

// ==========================================
// timing
`define WID_CLK_PERIOD_NS 10
`define WID_SLOW_PERIOD_NS 30518
`define WID_SLOW_DIV (`WID_SLOW_PERIOD_NS / `WID_CLK_PERIOD_NS)
`define WID_DBC_0 16'h0001
`define WID_DBC_1 16'h0003
`define WID_DBC_2 16'h0020
`define WID_DBC_3 16'h0200
`define WID_DBC_4 16'h1000
`define WID_DBC_5 16'h8000
`define WID_TAMP_DBC 4'h3
`define WID_DRIVE_PERIOD 4'hF

`endif

// ==== sim/wid_chk.sv ====
// port checker for the wake-up input debouncer
// assumes SLOW_DIV of 4 in the bound instance
`timescale 1ns/1ps
`default_nettype none
module wid_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic core_supply_wake,
  input wire logic [1:0] rtc_waveform_out
);
  // ==========================================
  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  a_wake_pulse: assert property (core_supply_wake |=> !core_supply_wake)
    else $error("wake longer than one cycle");
  a_wave_equal: assert property (rtc_waveform_out[0] == rtc_waveform_out[1])
    else $error("drive bits differ");
  a_wave_high: assert property ($rose(rtc_waveform_out[0]) |-> rtc_waveform_out[0] [*4] ##1 !rtc_waveform_out[0])
    else $error("drive high span wrong");
  a_wave_low: assert property ($fell(rtc_waveform_out[0]) |-> !rtc_waveform_out[0] [*8])
    else $error("drive low span too short");
endmodule
`default_nettype wire

// ==== sim/wid_pin_model.sv ====
// wake pins and tamper switches seen by the debouncer
// assumes the bench commands pin levels; slow adds an 8-cycle lag
`timescale 1ns/1ps
`default_nettype none
module wid_pin_model
(
  input wire logic pclk,
  input wire logic slow,
  input wire logic [15:0] level,
  output var logic [15:0] wake_input
);
  // ==========================================
  // delay line
  logic [127:0] lag = 128'h0;
  always @(posedge pclk)
    lag <= {lag[111:0], level};
  // a sluggish switch settles late, never early
  assign wake_input = slow ? lag[127:112] : level;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the wake-up input debouncer over APB
// assumes SLOW_DIV set to 4, so one slow tick is 4 pclk cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, core_supply_wake, slow, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pins, wake_input;
  logic [1:0] rtc_waveform_out;
  int fails, checked, n, i;
  int lim[5] = '{1, 3, 32, 512, 4096};
  // ==========================================
  // instances
  wid_wakeup_input_debouncer #(.SLOW_DIV(4)) u_wid_wakeup_input_debouncer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_input(wake_input), .core_supply_wake(core_supply_wake),
    .rtc_waveform_out(rtc_waveform_out), .irq(irq));
  wid_pin_model u_wid_pin_model (.pclk(pclk), .slow(slow), .level(pins), .wake_input(wake_input));
  // ==========================================
  // tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask
  // counts edges until the wake pulse, or hi+1 if none
  task automatic wait_wake(input int hi);
    n = 0;
    while (core_supply_wake !== 1'b1 && n <= hi)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // clock, reset, watchdog
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #1_000_000;
    fails++;
    finish_test;
  end
  // ==========================================
  // tests
  initial
  begin
    {presetn, psel, penable, pwrite, slow, paddr, pwdata, pins} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h10, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(perr, 1, "unmapped error");
    chk(rd, 0, "unmapped data");
    apb(1'b1, 8'h00, 32'h1);
    pins <= 16'h0008;
    wait_wake(200);
    chk(n > 200, 1, "disabled pin woke");
    apb(1'b1, 8'h04, 32'h0008_0008);
    wait_wake(40);
    chk(n <= 40, 1, "enabled pin");
    rdchk(8'h08, 32'h0001_0008);
    chk(irq, 0, "masked irq");
    wait_wake(100);
    chk(n > 100, 1, "second wake in one episode");
    apb(1'b1, 8'h10, 32'h1);
    rdchk(8'h0C, 32'h1);
    chk(irq, 1, "unmasked irq");
    pins <= 16'h0000;
    apb(1'b1, 8'h04, 32'h0000_0020);
    wait_wake(40);
    chk(n <= 40, 1, "low active pin");
    rdchk(8'h08, 32'h0001_0000);
    pins <= 16'h0020;
    apb(1'b1, 8'h0C, 32'h1);
    rdchk(8'h0C, 32'h0);
    chk(irq, 0, "irq after clear");
    apb(1'b1, 8'h04, 32'h0080_0080);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b1, 8'h00, i);
      pins <= 16'h0080;
      wait_wake(lim[i] * 4 + 8);
      chk(n >= lim[i] * 4 + 4 && n <= lim[i] * 4 + 7, 1, "debounce length");
      pins <= 16'h0000;
      repeat (20) @(posedge pclk);
    end
    apb(1'b1, 8'h00, 32'h5);
    pins <= 16'h0080;
    wait_wake(16400);
    chk(n > 16400, 1, "longest period too short");
    pins <= 16'h0000;
    apb(1'b1, 8'h00, 32'h2);
    repeat (12) @(posedge pclk);
    pins <= 16'h0080;
    repeat (80) @(posedge pclk);
    pins <= 16'h0000;
    repeat (12) @(posedge pclk);
    pins <= 16'h0080;
    wait_wake(80);
    chk(n > 80, 1, "count kept over a gap");
    wait_wake(100);
    chk(n <= 100, 1, "late wake");
    pins <= 16'h0000;
    slow <= 1'b1;
    apb(1'b1, 8'h04, 32'h0003_0000);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h0C, 32'h7);
      pins <= 16'h0001 << i;
      wait_wake(60);
      chk(n > 60, 1, "tamper while off");
      apb(1'b1, 8'h00, 32'h10 << i);
      wait_wake(40);
      chk(n <= 40, 1, "tamper wake");
      rdchk(8'h0C, 32'h2 << i);
      pins <= 16'h0000;
      repeat (20) @(posedge pclk);
    end
    rdchk(8'h14, 32'h0);
    pins <= 16'h0100;
    repeat (20) @(posedge pclk);
    rdchk(8'h14, 32'h0100);
    finish_test;
  end
endmodule
bind wid_wakeup_input_debouncer wid_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .core_supply_wake(core_supply_wake),
  .rtc_waveform_out(rtc_waveform_out));
`default_nettype wire
